// ### rtl/arb_regs.sv
// Functional notes
// - bit 5 inverts frame clock, or picks DSP mode B in DSP format
// - bit 6 selects master (drive clocks) or slave (clocks are inputs)
// - bit 7, master only: keep driving clocks after the source vanishes
// - selector bits 2:0 pick interrupt, channel 1-5 or link status for read-back
// - bit 3 enables continuous read-back mode
// - bit 4 enables status flags appended to audio output
// - bit 6 set passes full words, clear truncates per channel status 5
// - bit 7 high permits 192kHz receive, low caps at 96kHz; resets to 1
// - power-down bit 0 stops PLL, bit 1 stops receiver; both reset to 1
// - power-down bit 2 stops transmitter; resets to 1
// - power-down bit 3 stops oscillator; resets to 0
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "arb_defines.svh"

module arb_regs #(
  parameter int ADDR_W = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // datapath state feeding this bank
  input wire logic [1:0] rx_format_i,
  input wire logic source_present_i,
  input wire logic [7:0] int_status_i,
  input wire logic [7:0] chan_stat1_i,
  input wire logic [7:0] chan_stat2_i,
  input wire logic [7:0] chan_stat3_i,
  input wire logic [7:0] chan_stat4_i,
  input wire logic [7:0] chan_stat5_i,
  input wire logic [7:0] link_status_i,
  // controls to the datapath
  output logic rx_frame_clock_polarity_o,
  output logic dsp_mode_b_o,
  output logic audio_port_master_select_o,
  output logic audio_clk_output_enable_o,
  output logic [2:0] status_readback_selector_o,
  output logic [7:0] status_readback_data_o,
  output logic repeated_readback_enable_o,
  output logic append_status_flags_enable_o,
  output logic word_truncation_disable_o,
  output logic high_rate_receive_enable_o,
  output logic synthesizer_power_down_o,
  output logic receiver_power_down_o,
  output logic transmitter_power_down_o,
  output logic oscillator_power_down_o
);

  logic [7:0] aif_ff, nxt_aif;
  logic [7:0] rx_ctrl_ff, nxt_rx_ctrl;
  logic [7:0] pwr_ff, nxt_pwr;
  logic aw_hold_ff, nxt_aw_hold;
  logic w_hold_ff, nxt_w_hold;
  logic [7:0] aw_idx_ff, nxt_aw_idx;
  logic aw_ok_ff, nxt_aw_ok;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wlane_ff, nxt_wlane;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic aw_fire, w_fire, ar_fire, wr_do;
  logic [7:0] wr_idx, wr_data, ar_idx;
  logic wr_lane, wr_ok, ar_ok;
  logic [7:0] sel_word;
  logic fmt_is_dsp;

  // handshakes are combinational; ce low stalls every channel
  assign s_axi_awready_o = ce_i && !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready_o = ce_i && !w_hold_ff && !bvalid_ff;
  assign s_axi_arready_o = ce_i && !rvalid_ff;
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

  // address and data may arrive in either order; merge held and fresh halves
  assign wr_idx = aw_hold_ff ? aw_idx_ff : s_axi_awaddr_i[9:2];
  assign wr_ok = aw_hold_ff ? aw_ok_ff : (s_axi_awaddr_i[1:0] == `ARB_BYTE_OFS);
  assign wr_data = w_hold_ff ? wdata_ff : s_axi_wdata_i[7:0];
  assign wr_lane = w_hold_ff ? wlane_ff : s_axi_wstrb_i[0];
  assign wr_do = ce_i && !bvalid_ff && (aw_hold_ff || aw_fire) && (w_hold_ff || w_fire);
  assign ar_idx = s_axi_araddr_i[9:2];
  assign ar_ok = (s_axi_araddr_i[1:0] == `ARB_BYTE_OFS);

  // write channel sequencing and response
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_aw_idx = aw_idx_ff;
    nxt_aw_ok = aw_ok_ff;
    nxt_wdata = wdata_ff;
    nxt_wlane = wlane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (aw_fire) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_idx = s_axi_awaddr_i[9:2];
      nxt_aw_ok = (s_axi_awaddr_i[1:0] == `ARB_BYTE_OFS);
    end
    if (w_fire) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata_i[7:0];
      nxt_wlane = s_axi_wstrb_i[0];
    end
    if (wr_do) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      // unmapped addresses answer slverr and store nothing
      if (wr_ok && (wr_idx == `ARB_IDX_AIF_RX || wr_idx == `ARB_IDX_RX_CTRL ||
          wr_idx == `ARB_IDX_PWR_DN || wr_idx == `ARB_IDX_STAT_RB)) begin
        nxt_bresp = `ARB_RESP_OKAY;
      end else begin
        nxt_bresp = `ARB_RESP_SLVERR;
      end
    end else if (ce_i && bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
  end

  // register file next values; only byte lane 0 carries data
  always_comb begin
    nxt_aif = aif_ff;
    nxt_rx_ctrl = rx_ctrl_ff;
    nxt_pwr = pwr_ff;
    if (wr_do && wr_ok && wr_lane) begin
      case (wr_idx)
        `ARB_IDX_AIF_RX: begin
          nxt_aif = wr_data & `ARB_AIF_MASK;
        end
        `ARB_IDX_RX_CTRL: begin
          nxt_rx_ctrl = wr_data & `ARB_RX_MASK;
        end
        `ARB_IDX_PWR_DN: begin
          nxt_pwr = wr_data & `ARB_PD_MASK;
        end
        default: begin
          nxt_aif = aif_ff;
        end
      endcase
    end
  end

  always_comb begin
    case (arb_pkg::arb_sel_type'(rx_ctrl_ff[`ARB_RX_SEL_MSB:`ARB_RX_SEL_LSB]))
      arb_pkg::arb_sel_int_status: sel_word = int_status_i;
      arb_pkg::arb_sel_chan_stat1: sel_word = chan_stat1_i;
      arb_pkg::arb_sel_chan_stat2: sel_word = chan_stat2_i;
      arb_pkg::arb_sel_chan_stat3: sel_word = chan_stat3_i;
      arb_pkg::arb_sel_chan_stat4: sel_word = chan_stat4_i;
      arb_pkg::arb_sel_chan_stat5: sel_word = chan_stat5_i;
      arb_pkg::arb_sel_link_status: sel_word = link_status_i;
      default: sel_word = 8'h00;
    endcase
  end

  // read channel; data is captured at the address edge
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_fire) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `ARB_RESP_OKAY;
      if (!ar_ok) begin
        nxt_rresp = `ARB_RESP_SLVERR;
      end else begin
        case (ar_idx)
          `ARB_IDX_AIF_RX: nxt_rdata = {24'h00_0000, aif_ff};
          `ARB_IDX_RX_CTRL: nxt_rdata = {24'h00_0000, rx_ctrl_ff};
          `ARB_IDX_PWR_DN: nxt_rdata = {24'h00_0000, pwr_ff};
          // selector from register, written before this read
          `ARB_IDX_STAT_RB: nxt_rdata = {24'h00_0000, sel_word};
          default: nxt_rresp = `ARB_RESP_SLVERR;
        endcase
      end
    end else if (ce_i && rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  // state registers; reset wins over a low clock enable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      // PLL and receiver start powered down
      pwr_ff <= `ARB_PD_RST;
      rx_ctrl_ff <= `ARB_RX_RST;
      aif_ff <= `ARB_AIF_RST;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      aw_ok_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ARB_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `ARB_RESP_OKAY;
    end else if (ce_i) begin
      pwr_ff <= nxt_pwr;
      rx_ctrl_ff <= nxt_rx_ctrl;
      aif_ff <= nxt_aif;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      aw_idx_ff <= nxt_aw_idx;
      aw_ok_ff <= nxt_aw_ok;
      wdata_ff <= nxt_wdata;
      wlane_ff <= nxt_wlane;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // one bit, two meanings by format
  assign fmt_is_dsp = (arb_pkg::arb_fmt_type'(rx_format_i) == arb_pkg::arb_fmt_dsp);
  assign rx_frame_clock_polarity_o = aif_ff[`ARB_AIF_LRP_BIT] && !fmt_is_dsp;
  assign dsp_mode_b_o = aif_ff[`ARB_AIF_LRP_BIT] && fmt_is_dsp;
  assign audio_port_master_select_o = aif_ff[`ARB_AIF_ROLE_BIT];
  // slave never drives; master stops on source loss unless held
  assign audio_clk_output_enable_o = aif_ff[`ARB_AIF_ROLE_BIT] &&
    (source_present_i || aif_ff[`ARB_AIF_HOLD_BIT]);
  // selector and selected word to the read-back path
  assign status_readback_selector_o = rx_ctrl_ff[`ARB_RX_SEL_MSB:`ARB_RX_SEL_LSB];
  assign status_readback_data_o = sel_word;
  assign repeated_readback_enable_o = rx_ctrl_ff[`ARB_RX_REPEAT_BIT];
  assign append_status_flags_enable_o = rx_ctrl_ff[`ARB_RX_FLAG_BIT];
  assign word_truncation_disable_o = rx_ctrl_ff[`ARB_RX_WLM_BIT];
  assign high_rate_receive_enable_o = rx_ctrl_ff[`ARB_RX_HIRATE_BIT];
  assign synthesizer_power_down_o = pwr_ff[`ARB_PD_PLL_BIT];
  assign receiver_power_down_o = pwr_ff[`ARB_PD_RX_BIT];
  assign transmitter_power_down_o = pwr_ff[`ARB_PD_TX_BIT];
  assign oscillator_power_down_o = pwr_ff[`ARB_PD_OSC_BIT];

  // helper strobes for the checks below
  logic wr_aif, wr_rx, wr_pwr, rd_stat;
  assign wr_aif = wr_do && wr_ok && wr_lane && wr_idx == `ARB_IDX_AIF_RX;
  assign wr_rx = wr_do && wr_ok && wr_lane && wr_idx == `ARB_IDX_RX_CTRL;
  assign wr_pwr = wr_do && wr_ok && wr_lane && wr_idx == `ARB_IDX_PWR_DN;
  assign rd_stat = ar_fire && ar_ok && ar_idx == `ARB_IDX_STAT_RB;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_write_taken;
    wr_do;
  endsequence
  sequence s_resp_waits;
    s_axi_bvalid_o && !s_axi_bready_i;
  endsequence

  a_lrp_split_mode: assert property (
    wr_aif ##1 (ce_i && !$changed(rx_format_i)) |->
      (rx_frame_clock_polarity_o || dsp_mode_b_o) == $past(wr_data[`ARB_AIF_LRP_BIT]))
    else $error("frame clock bit does not follow write");
  a_master_select: assert property (
    wr_aif |=> audio_port_master_select_o == $past(wr_data[`ARB_AIF_ROLE_BIT]))
    else $error("master select not updated");
  a_clock_stop_lost: assert property (
    (!audio_port_master_select_o || (!source_present_i && !aif_ff[`ARB_AIF_HOLD_BIT])) |->
      !audio_clk_output_enable_o)
    else $error("clocks driven when they must stop");
  a_sel_readback: assert property (
    rd_stat |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(sel_word))
    else $error("read-back word not the selected status");
  a_sel_update: assert property (
    wr_rx |=> status_readback_selector_o == $past(wr_data[`ARB_RX_SEL_MSB:`ARB_RX_SEL_LSB]))
    else $error("selector not updated after write");
  a_mode_bits: assert property (
    wr_rx |=> {append_status_flags_enable_o, repeated_readback_enable_o} == $past(wr_data[4:3]))
    else $error("flag or continuous bits wrong");
  a_trunc_rate: assert property (
    wr_rx |=> {high_rate_receive_enable_o, word_truncation_disable_o} == $past(wr_data[7:6]))
    else $error("truncation or rate bit wrong");
  a_power_reset: assert property (
    $fell(rst_i) |-> pwr_ff == `ARB_PD_RST && rx_ctrl_ff == `ARB_RX_RST)
    else $error("reset values wrong");
  a_power_write: assert property (
    wr_pwr |=> {oscillator_power_down_o, transmitter_power_down_o,
      receiver_power_down_o, synthesizer_power_down_o} == $past(wr_data[3:0]))
    else $error("power bits not updated");
  a_reserved_zero: assert property (
    aif_ff[4:0] == 5'h00 && rx_ctrl_ff[5] == 1'b0 && pwr_ff[7:4] == 4'h0)
    else $error("reserved bit set");
  a_write_resp: assert property (
    s_write_taken |=> s_axi_bvalid_o)
    else $error("no response after write");
  a_resp_holds: assert property (
    s_resp_waits |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");

endmodule : arb_regs

// ### rtl/arb_defines.svh
`ifndef ARB_DEFINES_SVH
`define ARB_DEFINES_SVH

// register indices; byte address is four times the index
`define ARB_IDX_AIF_RX 8'h1C
`define ARB_IDX_RX_CTRL 8'h1D
`define ARB_IDX_PWR_DN 8'h1E
`define ARB_IDX_STAT_RB 8'h1F

// receive audio port config fields
`define ARB_AIF_LRP_BIT 5
`define ARB_AIF_ROLE_BIT 6
`define ARB_AIF_HOLD_BIT 7
`define ARB_AIF_MASK 8'hE0
`define ARB_AIF_RST 8'h00

// receiver read-back control fields
`define ARB_RX_SEL_MSB 2
`define ARB_RX_SEL_LSB 0
`define ARB_RX_REPEAT_BIT 3
`define ARB_RX_FLAG_BIT 4
`define ARB_RX_WLM_BIT 6
`define ARB_RX_HIRATE_BIT 7
`define ARB_RX_MASK 8'hDF
`define ARB_RX_RST 8'h80

// power-down fields
`define ARB_PD_PLL_BIT 0
`define ARB_PD_RX_BIT 1
`define ARB_PD_TX_BIT 2
`define ARB_PD_OSC_BIT 3
`define ARB_PD_MASK 8'h0F
`define ARB_PD_RST 8'h07

// bus answers
`define ARB_RESP_OKAY 2'h0
`define ARB_RESP_SLVERR 2'h2
`define ARB_BYTE_OFS 2'h0

`endif

// ### rtl/arb_pkg.sv
package arb_pkg;

  // status read-back selector codes
  typedef enum logic [2:0] {
    arb_sel_int_status = 3'h0,
    arb_sel_chan_stat1 = 3'h1,
    arb_sel_chan_stat2 = 3'h2,
    arb_sel_chan_stat3 = 3'h3,
    arb_sel_chan_stat4 = 3'h4,
    arb_sel_chan_stat5 = 3'h5,
    arb_sel_link_status = 3'h6
  } arb_sel_type;

  // audio data formats of the receive port
  typedef enum logic [1:0] {
    arb_fmt_right = 2'h0,
    arb_fmt_left = 2'h1,
    arb_fmt_i2s = 2'h2,
    arb_fmt_dsp = 2'h3
  } arb_fmt_type;

endpackage : arb_pkg

// ### verification/test_audio_rx_readback_power_regs.sv
`timescale 1ns/100ps
`include "arb_defines.svh"

module test_audio_rx_readback_power_regs;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, src = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [7:0] stat [7] = '{default: 8'h00};
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire lrp, dspb, ms, clk_oe, rpt, flag, wlm, hirate, pll_pd, rx_pd, tx_pd, osc_pd;
  wire [2:0] sel;
  wire [7:0] rb_data;
  logic [7:0] aif_m, rxc_m, pwr_m;
  int mismatches = 0;
  int checks = 0;
  logic [9:0] map [4] = '{10'h070, 10'h074, 10'h078, 10'h07C};

  // free-running system clock, 25 ns period
  always #12.5 clk_sys_i = ~clk_sys_i;

  arb_regs dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rx_format_i(fmt), .source_present_i(src), .int_status_i(stat[0]), .chan_stat1_i(stat[1]),
    .chan_stat2_i(stat[2]), .chan_stat3_i(stat[3]), .chan_stat4_i(stat[4]), .chan_stat5_i(stat[5]),
    .link_status_i(stat[6]), .rx_frame_clock_polarity_o(lrp), .dsp_mode_b_o(dspb),
    .audio_port_master_select_o(ms), .audio_clk_output_enable_o(clk_oe),
    .status_readback_selector_o(sel), .status_readback_data_o(rb_data),
    .repeated_readback_enable_o(rpt), .append_status_flags_enable_o(flag),
    .word_truncation_disable_o(wlm), .high_rate_receive_enable_o(hirate),
    .synthesizer_power_down_o(pll_pd), .receiver_power_down_o(rx_pd),
    .transmitter_power_down_o(tx_pd), .oscillator_power_down_o(osc_pd));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // expected read data, worked out from the shadow copy
  function automatic logic [31:0] exp_read(input logic [9:0] a);
    case (a)
      10'h070: return {24'h0, aif_m};
      10'h074: return {24'h0, rxc_m};
      10'h078: return {24'h0, pwr_m};
      10'h07C: return (rxc_m[2:0] == 3'h7) ? 32'h0 : {24'h0, stat[rxc_m[2:0]]};
      default: return 32'h0;
    endcase
  endfunction : exp_read

  function automatic logic [1:0] exp_resp(input logic [9:0] a);
    return (a inside {10'h070, 10'h074, 10'h078, 10'h07C}) ? 2'h0 : 2'h2;
  endfunction : exp_resp

  task automatic model_reset;
    aif_m = 8'h00;
    rxc_m = 8'h80;
    pwr_m = 8'h07;
  endtask : model_reset

  // readies are looked at on the falling edge, where nothing the bench drives is moving
  task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    logic aw_ok, w_ok, ta, tw;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_sys_i);
      ta = !aw_ok && awready === 1'b1;
      tw = !w_ok && wready === 1'b1;
      @(posedge clk_sys_i);
      if (ta) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(negedge clk_sys_i); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge clk_sys_i);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_sys_i); while (arready !== 1'b1);
    @(posedge clk_sys_i);
    arvalid <= 1'b0;
    do @(negedge clk_sys_i); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    @(posedge clk_sys_i);
    rready <= 1'b0;
  endtask : axi_read

  // every control output against the shadow registers and the live inputs
  task automatic check_outs;
    @(negedge clk_sys_i);
    check(lrp, aif_m[5] & (fmt != 2'h3));
    check(dspb, aif_m[5] & (fmt == 2'h3));
    check(ms, aif_m[6]);
    check(clk_oe, aif_m[6] & (src | aif_m[7]));
    check(sel, rxc_m[2:0]);
    check(rb_data, exp_read(10'h07C));
    check(rpt, rxc_m[3]);
    check(flag, rxc_m[4]);
    check(wlm, rxc_m[6]);
    check(hirate, rxc_m[7]);
    check({rx_pd, pll_pd}, pwr_m[1:0]);
    check(tx_pd, pwr_m[2]);
    check(osc_pd, pwr_m[3]);
  endtask : check_outs

  // write, mirror into the shadow copy, read back
  task automatic wr_rd(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    logic [31:0] rd;
    axi_write(a, d, s, r);
    check(r, exp_resp(a));
    if (s[0] && a == 10'h070) aif_m = d[7:0] & `ARB_AIF_MASK;
    if (s[0] && a == 10'h074) rxc_m = d[7:0] & `ARB_RX_MASK;
    if (s[0] && a == 10'h078) pwr_m = d[7:0] & `ARB_PD_MASK;
    axi_read(a, rd, r);
    check(rd, exp_read(a));
    check(r, exp_resp(a));
    check_outs();
  endtask : wr_rd

  task automatic defaults(input string name);
    logic [1:0] r;
    logic [31:0] rd;
    model_reset();
    check_outs();
    for (int i = 0; i < 4; i++) begin
      axi_read(map[i], rd, r);
      check(rd, exp_read(map[i]));
    end
    $display("test %s done", name);
  endtask : defaults

  // cuts a hung handshake short; the whole run needs well under a thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    mismatches++;
    conclude();
  end

  initial begin
    logic [1:0] r;
    logic [31:0] rd;
    void'($urandom(83019));
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    defaults("reset");
    // random writes with all-ones and all-zeros first, format and source moving underneath
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_sys_i);
      fmt <= 2'($urandom);
      src <= 1'($urandom);
      wr_rd(map[$urandom % 3], (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom, 4'($urandom | i));
    end
    $display("test random_rw done");
    // every selector code including the unused one; new code serves the very next read
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_sys_i);
      for (int k = 0; k < 7; k++) stat[k] <= 8'($urandom);
      wr_rd(10'h074, ($urandom & 32'h000000F8) | s, 4'h1);
      axi_read(10'h07C, rd, r);
      check(rd, exp_read(10'h07C));
    end
    $display("test selector done");
    // unmapped, misaligned, read-only and no-strobe accesses store nothing
    wr_rd(10'h080, 32'hFF, 4'hF);
    wr_rd(10'h071, 32'h00, 4'hF);
    wr_rd(10'h3FC, 32'h00, 4'hF);
    wr_rd(10'h07C, 32'hFF, 4'hF);
    wr_rd(10'h078, 32'h08, 4'hE);
    $display("test refused done");
    // clock enable low must hold every ready down
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    @(negedge clk_sys_i);
    check({awready, wready, arready}, 3'h0);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    wr_rd(10'h070, 32'hC0, 4'h1);
    $display("test clock_enable done");
    // second reset in mid-run brings the defaults back
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    defaults("second_reset");
    conclude();
  end
endmodule : test_audio_rx_readback_power_regs
